// ==== core/ccpc_top.sv ====
// Processor clock-rate, sleep, halt and wake control with interrupt mask.
// Assumes a one-cycle strobe register port; pins come from other domains.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ccpc_top
   import ccpc_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   // Register port.
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Wake sources and booster status from pins.
   input wire ccpc_wake_pins_t wake_pins,
   input wire logic parallel_host_port_rd,
   input wire logic booster_rail_low,
   // Pending interrupt requests, same clock.
   input wire logic [15:0] irq_raw,
   // Clocking, power and interrupt outputs.
   output logic cpu_tick,
   output logic periph_tick,
   output logic clock_run,
   output logic analog_pwr_dn,
   output logic discard_serial_byte,
   output logic [15:0] irq_pending,
   output logic [15:0] irq_enable_mask,
   output logic [2:0] irq_pending_flush
);
   ////////////////////////////////////////////////////////////////////////
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronise every pin before use.
   localparam int NPIN = 12;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s;
   logic [NPIN-1:0] pin_d;
   assign pin_raw = {booster_rail_low, parallel_host_port_rd, wake_pins};
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         ccpc_sync u_sync (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .d(pin_raw[gi]),
            .q(pin_s[gi])
         );
      end
   endgenerate
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_d <= 12'h3FF;
      end else begin
         pin_d <= pin_s;
      end
   end
   // Edge detect; the delay flop only starts comparing after one sample.
   logic pins_primed;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_primed <= 1'b0;
      end else begin
         pins_primed <= 1'b1;
      end
   end
   wire [NPIN-1:0] pin_chg = pins_primed ? (pin_s ^ pin_d) : 12'h000;
   wire [NPIN-1:0] pin_fall = pin_chg & pin_d;
   wire [NPIN-1:0] pin_rise = pin_chg & pin_s;

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [3:0] cpu_div;
   logic [15:0] pwr_ctl;
   logic [15:0] ien;
   ccpc_state_t state;
   ccpc_state_t next_state;

   wire sel_div = (reg_addr == CCPC_OFS_DIV);
   wire sel_pwr = (reg_addr == CCPC_OFS_PWR);
   wire sel_ien = (reg_addr == CCPC_OFS_IEN);
   wire wr_div = reg_wr && sel_div;
   wire wr_pwr = reg_wr && sel_pwr;
   wire wr_ien = reg_wr && sel_ien;
   wire boost_low = pin_s[11];

   // Writing one requests; writing zero has no function.
   wire req_sleep = wr_pwr && reg_wdata[CCPC_PWR_SLEEP];
   wire req_halt = wr_pwr && reg_wdata[CCPC_PWR_HALT] && !reg_wdata[CCPC_PWR_SLEEP];

   // Wake sources gated by their enables.
   wire w_usb = |(pin_chg[9:6] & pwr_ctl[CCPC_PWR_USB_LO +: 4]);
   wire w_otg = pwr_ctl[CCPC_PWR_OTG] && (pin_chg[5] || pin_chg[4]);
   wire w_fsl = pwr_ctl[CCPC_PWR_FSL] && pin_chg[3];
   wire w_spi = pwr_ctl[CCPC_PWR_SPI] && pin_fall[2];
   wire w_hpt = pwr_ctl[CCPC_PWR_HPORT] && pin_rise[10];
   wire w_gpi = pwr_ctl[CCPC_PWR_GPI] && (pin_chg[1] || pin_chg[0]);
   wire wake_any = w_usb || w_otg || w_fsl || w_spi || w_hpt || w_gpi;
   wire irq_hit = |(irq_raw & ien);

   ////////////////////////////////////////////////////////////////////////
   // Power state machine.
   logic [15:0] resume_cnt;
   wire resume_done = (resume_cnt == 16'(CCPC_RESUME_CYC - 1));
   always_comb begin
      next_state = state;
      unique case (state)
         CCPC_RUN: begin
            if (req_sleep) begin
               next_state = CCPC_SLEEP;
            end else if (req_halt) begin
               next_state = CCPC_HALT;
            end
         end
         CCPC_HALT: begin
            if (req_sleep) begin
               next_state = CCPC_SLEEP;
            end else if (irq_hit) begin
               next_state = CCPC_RUN;
            end
         end
         CCPC_SLEEP: begin
            if (wake_any) begin
               next_state = CCPC_RESUME;
            end
         end
         CCPC_RESUME: begin
            if (resume_done) begin
               next_state = CCPC_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CCPC_RUN;
         resume_cnt <= 16'h0000;
      end else begin
         state <= next_state;
         resume_cnt <= (state == CCPC_RESUME) ? resume_cnt + 16'h0001 : 16'h0000;
      end
   end

   // Stored bits ignore reserved positions.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_div <= CCPC_DIV_RESET;
         pwr_ctl <= CCPC_PWR_RESET;
         ien <= CCPC_IEN_RESET;
      end else begin
         if (wr_div) begin
            cpu_div <= reg_wdata[3:0];
         end
         if (wr_pwr) begin
            pwr_ctl <= reg_wdata & CCPC_PWR_WMASK;
         end
         if (wr_ien) begin
            ien <= reg_wdata & CCPC_IEN_WMASK;
         end
      end
   end

   // The request bits read as the live mode, so they drop on return to run, after the resume for sleep.
   wire [15:0] pwr_rd = pwr_ctl |
      {13'h0000, boost_low,
       (state == CCPC_SLEEP) || (state == CCPC_RESUME), state == CCPC_HALT};

   logic [15:0] next_rdata;
   assign next_rdata = !reg_rd ? 16'h0000 :
      sel_div ? {12'h000, cpu_div} :
      sel_pwr ? pwr_rd :
      sel_ien ? ien : 16'h0000;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clocking outputs.
   wire cpu_run = (state == CCPC_RUN);
   ccpc_divider u_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .div(cpu_div),
      .run(cpu_run),
      .cpu_tick(cpu_tick)
   );
   // Peripherals tick every clock except in sleep, which freezes timers.
   assign periph_tick = (state != CCPC_SLEEP);
   assign clock_run = (state != CCPC_SLEEP);
   assign analog_pwr_dn = (state == CCPC_SLEEP);
   // The byte that woke us through serial or select is dropped.
   assign discard_serial_byte = (state != CCPC_RUN) && (state != CCPC_HALT);
   assign irq_pending = irq_raw & ien;
   assign irq_enable_mask = ien;
   // Flush pulses when enables for general IO or timers are cleared.
   assign irq_pending_flush = wr_ien ? (ien[2:0] & ~reg_wdata[2:0]) : 3'b000;

   ////////////////////////////////////////////////////////////////////////
   property p_sleep_enter;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_RUN && req_sleep) |=> analog_pwr_dn && !clock_run;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
   property p_halt_enter;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_RUN && req_halt) |=> !cpu_tick && periph_tick;
   endproperty
   a_halt_enter: assert property (p_halt_enter) else $error("halt wrong");
   property p_div_zero;
      @(posedge ref_clk) disable iff (!rst_n)
         (cpu_div == 4'h0 && cpu_run && $stable(cpu_div)) |-> cpu_tick;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("divide by one fails");
   property p_div_gap;
      @(posedge ref_clk) disable iff (!rst_n)
         (cpu_tick && cpu_div == 4'h2 && $stable(cpu_div)) |=> !cpu_tick;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("tick too soon");
   sequence s_wake;
      state == CCPC_SLEEP ##1 state == CCPC_RESUME;
   endsequence
   // The resume span is far too long for a delay range, so a saturating age
   // counter of its own watches it instead of the state machine's counter.
   logic [15:0] chk_resume_age;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_resume_age <= 16'h0000;
      end else if (state != CCPC_RESUME) begin
         chk_resume_age <= 16'h0000;
      end else if (chk_resume_age != 16'hFFFF) begin
         chk_resume_age <= chk_resume_age + 16'h0001;
      end
   end
   property p_resume;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_RESUME) |-> (chk_resume_age < 16'(CCPC_RESUME_CYC));
   endproperty
   a_resume: assert property (p_resume) else $error("resume too slow");
   property p_wake_seq;
      @(posedge ref_clk) disable iff (!rst_n)
         s_wake |-> clock_run && !analog_pwr_dn && discard_serial_byte;
   endproperty
   a_wake_seq: assert property (p_wake_seq) else $error("wake left power down");
   property p_halt_exit;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_HALT && irq_hit && !req_sleep) |=> state == CCPC_RUN;
   endproperty
   a_halt_exit: assert property (p_halt_exit) else $error("halt not exited");
   property p_sleep_hold;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_SLEEP && !wake_any) |=> state == CCPC_SLEEP && !periph_tick;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left early");
   property p_flush;
      @(posedge ref_clk) disable iff (!rst_n)
         (wr_ien && ien[CCPC_IEN_GPIO] && !reg_wdata[CCPC_IEN_GPIO]) |-> irq_pending_flush[2];
   endproperty
   a_flush: assert property (p_flush) else $error("gpio flush missing");
   property p_tmr_flush;
      @(posedge ref_clk) disable iff (!rst_n)
         (wr_ien && ien[CCPC_IEN_TMR1] && !reg_wdata[CCPC_IEN_TMR1]) |-> irq_pending_flush[1];
   endproperty
   a_tmr_flush: assert property (p_tmr_flush) else $error("timer flush missing");
   property p_zero_write;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_RUN && wr_pwr && reg_wdata[1:0] == 2'b00) |=> state == CCPC_RUN;
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write acted");
   property p_spi_wake;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_SLEEP && w_spi) |=> state == CCPC_RESUME && discard_serial_byte;
   endproperty
   a_spi_wake: assert property (p_spi_wake) else $error("select wake missed");
   property p_usb_wake;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_SLEEP && w_usb) |=> state == CCPC_RESUME;
   endproperty
   a_usb_wake: assert property (p_usb_wake) else $error("usb wake missed");
   property p_fsl_wake;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_SLEEP && w_fsl) |=> state == CCPC_RESUME && discard_serial_byte;
   endproperty
   a_fsl_wake: assert property (p_fsl_wake) else $error("serial wake missed");
   property p_hpt_wake;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_SLEEP && w_hpt) |=> state == CCPC_RESUME;
   endproperty
   a_hpt_wake: assert property (p_hpt_wake) else $error("host port wake missed");
   property p_gpi_wake;
      @(posedge ref_clk) disable iff (!rst_n)
         (state == CCPC_SLEEP && w_gpi) |=> state == CCPC_RESUME;
   endproperty
   a_gpi_wake: assert property (p_gpi_wake) else $error("general input wake missed");
   property p_tmr0_flush;
      @(posedge ref_clk) disable iff (!rst_n)
         (wr_ien && ien[CCPC_IEN_TMR0] && !reg_wdata[CCPC_IEN_TMR0]) |-> irq_pending_flush[0];
   endproperty
   a_tmr0_flush: assert property (p_tmr0_flush) else $error("timer 0 flush missing");
   property p_booster;
      @(posedge ref_clk) disable iff (!rst_n)
         (reg_rd && sel_pwr) |=> reg_rdata[CCPC_PWR_BOOST] == $past(boost_low);
   endproperty
   a_booster: assert property (p_booster) else $error("booster status wrong");
   property p_periph_run;
      @(posedge ref_clk) disable iff (!rst_n)
         (state != CCPC_SLEEP) |-> periph_tick && clock_run;
   endproperty
   a_periph_run: assert property (p_periph_run) else $error("peripheral tick stopped");
endmodule
`default_nettype wire

// ==== core/ccpc_pkg.sv ====
// Package for the processor clock and power control block.
// Assumes a 16-bit register port at byte offsets, one clock domain.
package ccpc_pkg;
   // Register byte offsets.
   localparam logic [15:0] CCPC_OFS_DIV = 16'hC008;
   localparam logic [15:0] CCPC_OFS_PWR = 16'hC00A;
   localparam logic [15:0] CCPC_OFS_IEN = 16'hC00E;
   // Reset values.
   localparam logic [3:0] CCPC_DIV_RESET = 4'hF;
   localparam logic [15:0] CCPC_PWR_RESET = 16'h0000;
   localparam logic [15:0] CCPC_IEN_RESET = 16'h0000;
   // Writable masks.
   localparam logic [15:0] CCPC_PWR_WMASK = 16'hFB90;
   localparam logic [15:0] CCPC_IEN_WMASK = 16'h1BEF;
   // Power register field positions.
   localparam int CCPC_PWR_HALT = 0;
   localparam int CCPC_PWR_SLEEP = 1;
   localparam int CCPC_PWR_BOOST = 2;
   localparam int CCPC_PWR_GPI = 4;
   localparam int CCPC_PWR_HPORT = 7;
   localparam int CCPC_PWR_SPI = 8;
   localparam int CCPC_PWR_FSL = 9;
   localparam int CCPC_PWR_OTG = 11;
   localparam int CCPC_PWR_USB_LO = 12;
   // Interrupt mask field positions.
   localparam int CCPC_IEN_TMR0 = 0;
   localparam int CCPC_IEN_TMR1 = 1;
   localparam int CCPC_IEN_GPIO = 2;
   // Resume time after sleep: 0.5 ms longest, exactly 20000 cycles at 40 MHz.
   localparam int CCPC_CLK_HZ = 40000000;
   localparam int CCPC_RESUME_US = 500;
   localparam int CCPC_RESUME_CYC = (CCPC_CLK_HZ / 1000000) * CCPC_RESUME_US;
   // Wake pin bundle.
   typedef struct packed {
      logic [3:0] usb_line;
      logic otg_vbus_valid;
      logic otg_id;
      logic fast_serial_link_rx;
      logic peripheral_select_n;
      logic [1:0] general_input_wake;
   } ccpc_wake_pins_t;
   typedef enum logic [1:0] {
      CCPC_RUN = 2'b00,
      CCPC_HALT = 2'b01,
      CCPC_SLEEP = 2'b10,
      CCPC_RESUME = 2'b11
   } ccpc_state_t;
endpackage

// ==== core/ccpc_sync.sv ====
// Two-flop synchroniser for one pin.
// Assumes an active-low asynchronous reset on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ccpc_sync (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Data.
   input wire logic d,
   output logic q
);
   logic meta;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== core/ccpc_divider.sv ====
// Processor clock-enable divider: one pulse every div+1 clocks.
// Assumes the divisor is stable or may change at any time.
`timescale 1ns/10ps
`default_nettype none
module ccpc_divider (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control.
   input wire logic [3:0] div,
   input wire logic run,
   output logic cpu_tick
);
   logic [3:0] cnt;
   // Counter freezes while not running, so the phase is kept over a stop.
   assign cpu_tick = run && (cnt >= div);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
      end else if (run) begin
         cnt <= cpu_tick ? 4'h0 : cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ==== bench/test_cpu_clock_power_control.sv ====
// Self-checking bench for the processor clock and power control block.
// Assumes the strobe register port and the wake pin bundle of ccpc_pkg.
`timescale 1ns/10ps
`default_nettype none
module test_cpu_clock_power_control;
   import ccpc_pkg::*;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   // Bits 9:0 form the pin bundle, bit 10 is the host port read level; select idles high.
   logic [10:0] src = 11'h004;
   ccpc_wake_pins_t wp;
   logic booster_rail_low = 1'b0;
   logic [15:0] irq_raw = 16'h0000;
   logic cpu_tick, periph_tick, clock_run, analog_pwr_dn, discard_serial_byte;
   logic [15:0] irq_pending, irq_enable_mask, rd_val;
   logic [2:0] irq_pending_flush, flush_seen;
   int miscompares = 0;
   int checks_done = 0;
   int n, k, d, ticks;
   assign wp = src[9:0];
   always #12.5 ref_clk = ~ref_clk;
   ccpc_top i_ccpc_top (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_pins(wp),
      .parallel_host_port_rd(src[10]), .booster_rail_low(booster_rail_low), .irq_raw(irq_raw),
      .cpu_tick(cpu_tick), .periph_tick(periph_tick), .clock_run(clock_run), .analog_pwr_dn(analog_pwr_dn),
      .discard_serial_byte(discard_serial_byte), .irq_pending(irq_pending),
      .irq_enable_mask(irq_enable_mask), .irq_pending_flush(irq_pending_flush));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      #1 flush_seen = irq_pending_flush;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1 flush_seen = flush_seen | irq_pending_flush;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   // Pins go back to idle while reset is held, so on release only a select rise from the cleared synchronisers is seen.
   task automatic rst_dut();
      @(posedge ref_clk);
      arst_n <= 1'b0;
      src <= 11'h004;
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic wait_resume();
      n = 0;
      #1;
      while (analog_pwr_dn !== 1'b0 && n < 10) begin
         @(posedge ref_clk);
         #1 n++;
      end
   endtask
   function automatic logic [15:0] en_of(input int i);
      case (i)
         9, 8, 7, 6: en_of = 16'h1000 << (i - 6);
         5, 4: en_of = 16'h0800;
         3: en_of = 16'h0200;
         2: en_of = 16'h0100;
         10: en_of = 16'h0080;
         default: en_of = 16'h0010;
      endcase
   endfunction
   task automatic stop_test();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_dut();
      rd(CCPC_OFS_DIV); `CHK(rd_val, 16'h000F)
      booster_rail_low <= 1'b1;
      rd(CCPC_OFS_IEN); `CHK(rd_val, 16'h0000)
      rd(CCPC_OFS_PWR); `CHK(rd_val, 16'h0004)
      booster_rail_low <= 1'b0;
      rd(16'hC00C); `CHK(rd_val, 16'h0000)
      wr(CCPC_OFS_IEN, CCPC_IEN_WMASK);
      rd(CCPC_OFS_IEN); `CHK(rd_val, CCPC_IEN_WMASK)
      `CHK(irq_enable_mask, CCPC_IEN_WMASK)
      wr(CCPC_OFS_IEN, 16'h1BEE); `CHK(flush_seen, 3'b001)
      wr(CCPC_OFS_IEN, 16'h1BEC); `CHK(flush_seen, 3'b010)
      wr(CCPC_OFS_IEN, 16'h1BE8); `CHK(flush_seen, 3'b100)
      wr(CCPC_OFS_IEN, 16'h0001); `CHK(flush_seen, 3'b000)
      // Every divisor code: eight processor ticks in eight full periods.
      for (d = 0; d < 16; d++) begin
         wr(CCPC_OFS_DIV, 16'(d));
         rd(CCPC_OFS_DIV); `CHK(rd_val, 16'(d))
         repeat (2 * (d + 1)) @(posedge ref_clk);
         ticks = 0;
         n = 0;
         repeat (8 * (d + 1)) begin
            @(posedge ref_clk);
            #1 ticks += (cpu_tick === 1'b1);
            n += (periph_tick !== 1'b1);
         end
         `CHK(ticks, 8)
         `CHK(n, 0)
      end
      // Halt: processor stops, peripherals run, only an enabled request wakes.
      wr(CCPC_OFS_PWR, 16'h0001);
      rd(CCPC_OFS_PWR); `CHK(rd_val, 16'h0001)
      ticks = 0;
      repeat (40) begin
         @(posedge ref_clk);
         #1 ticks += (cpu_tick === 1'b1) + (periph_tick !== 1'b1) + (clock_run !== 1'b1);
      end
      `CHK(ticks, 0)
      irq_raw <= 16'h0002;
      repeat (5) @(posedge ref_clk);
      #1 `CHK(irq_pending, 16'h0000)
      rd(CCPC_OFS_PWR); `CHK(rd_val, 16'h0001)
      irq_raw <= 16'h0003;
      repeat (2) @(posedge ref_clk);
      #1 `CHK(irq_pending, 16'h0001)
      rd(CCPC_OFS_PWR); `CHK(rd_val, 16'h0000)
      // The slots after the halt instruction, meant for two no-ops, get ticks again.
      ticks = 0;
      repeat (32) begin
         @(posedge ref_clk);
         #1 ticks += (cpu_tick === 1'b1);
      end
      `CHK(ticks, 2)
      irq_raw <= 16'h0000;
      // Full sleep, select wake and resume time.
      rst_dut();
      wr(CCPC_OFS_PWR, 16'h0102);
      src[2] <= 1'b0;
      wait_resume(); `CHK(n < 10, 1'b1)
      rd(CCPC_OFS_PWR); `CHK(rd_val, 16'h0102)
      n = 3;
      while (discard_serial_byte === 1'b1 && n < 25000) begin
         @(posedge ref_clk);
         #1 n++;
      end
      `CHK(n <= CCPC_RESUME_CYC + 2, 1'b1)
      rd(CCPC_OFS_PWR); `CHK(rd_val, 16'h0100)
      `CHK(clock_run, 1'b1)
      // A disabled source leaves the device asleep.
      rst_dut();
      wr(CCPC_OFS_PWR, 16'h0012);
      src[9] <= 1'b1;
      repeat (10) @(posedge ref_clk);
      #1 `CHK(analog_pwr_dn, 1'b1)
      // Each wake source in turn; reset cuts the resume short.
      for (k = 0; k < 11; k++) begin
         rst_dut();
         wr(CCPC_OFS_PWR, en_of(k) | 16'h0002);
         @(posedge ref_clk);
         #1 `CHK({analog_pwr_dn, clock_run, periph_tick, cpu_tick, discard_serial_byte}, 5'b10001)
         @(posedge ref_clk);
         src[k] <= ~src[k];
         wait_resume(); `CHK(n < 10, 1'b1)
         `CHK(discard_serial_byte, 1'b1)
      end
      stop_test();
   end
endmodule
`default_nettype wire
